/* hw/rpio_panel_io.sv */
// Peripheral bus and panel I/O of the remote control unit controller.
// Assumes pin inputs are asynchronous and a user command port on clock.
//
// Notes on behaviour
// - Address-latch strobe always runs, 6 of 32 cycles high
// - Data port: tristate transfers, latched for panel
// - Port two: A0-A6 low bits, tape bit7
// - Port one: switch returns in, row selects out
// - Received character drives active-low interrupt
// - Framing error readable on a test input
// - Channel on A0-A3, latched by strobe rise
// - Complementary power-on resets for quarter second
// - A2-A5 decode sixteen selects, A6 enables
// - Write: data, address, A6 low, A6 high
// - Read: tristate, address, A6 low, sample, release
// - Codes select displays, UART and converter
// - A1-A0 pick display character position
// - One converter read returns and restarts
// - UART clock is strobe divided by two
// - UART frames: eight data, no parity, two stops
// - Display write clocks ASCII into position
// - LED sinks off during peripheral transfers
// - Ports reset high; row selects inverted
// - LED groups: data, row low, row high
// - Switch columns scanned after LEDs; diagnostic
`timescale 1ns/1ps
`include "rpio_defs.svh"
module rpio_panel_io
    import rpio_pkg::*;
#(
    parameter int POR_CYC = `RPIO_POR_CYC,
    parameter int LED_CYC = `RPIO_LED_CYC,
    parameter int ADC_CYC = `RPIO_ADC_CYC
) (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        ce,
    input  wire logic        reqValid,
    input  wire rpio_req_t   req,
    output logic             reqReady,
    output logic      [7:0]  rdData,
    output logic             rdValid,
    input  wire logic [31:0] ledData,
    input  wire logic        diagMode,
    output logic             scanDone,
    output logic      [31:0] switchState,
    input  wire logic [7:0]  busIn,
    output logic      [7:0]  busOut,
    output logic             busOe,
    output logic             busLatchMode,
    output logic      [6:0]  addrOut,
    output logic             tapeOut,
    output logic      [15:0] chipSelN,
    output logic             channel_latch_strobe_n,
    input  wire logic [3:0]  switch_return_bits,
    output logic      [3:0]  led_row_select,
    output logic      [3:0]  ledSinkOn,
    input  wire logic        char_received,
    input  wire logic        framing_error_input,
    output logic             cpuIntN,
    output logic             frameErrFlag,
    output logic             aleStrobe,
    output logic             tx_bit_clock,
    output logic             power_on_reset_n,
    output logic             power_on_reset_pos
);

    localparam logic [5:0]  ALE_CYC  = 6'(`RPIO_ALE_CYC);
    localparam logic [5:0]  ALE_HIGH = 6'(`RPIO_ALE_HIGH);
    localparam logic [11:0] STEP     = 12'(`RPIO_STEP_CYC);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] colOneHot(input logic [2:0] col);
        colOneHot = 8'h01 << col;
    endfunction

    function automatic logic [7:0] ledByte(input logic [31:0] leds, input logic [2:0] grp);
        ledByte = leds[grp[1:0]*8 +: 8];
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [13:0] syncA_ff;
    logic [13:0] syncB_ff;
    logic [7:0]  busSync;
    logic [3:0]  swSync;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            syncA_ff <= 14'h0000;
            syncB_ff <= 14'h0000;
        end else if (ce) begin
            syncA_ff <= {framing_error_input, char_received, switch_return_bits, busIn};
            syncB_ff <= syncA_ff;
        end
    end

    assign busSync      = syncB_ff[7:0];
    assign swSync       = syncB_ff[11:8];
    assign cpuIntN      = ~syncB_ff[12];
    assign frameErrFlag = syncB_ff[13];

    // ------------------------------------------------------------------
    // Address-latch strobe and UART bit clock
    // ------------------------------------------------------------------
    // The UART itself is strapped for 8N2 framing; only its clock is made here
    logic [5:0] aleCnt_ff;
    logic [5:0] nxt_aleCnt;
    logic       ale_ff;
    logic       nxt_ale;
    logic       uartClk_ff;
    logic       nxt_uartClk;

    always_comb begin
        nxt_aleCnt  = (aleCnt_ff == ALE_CYC - 6'h01) ? 6'h00 : aleCnt_ff + 6'h01;
        nxt_ale     = (nxt_aleCnt < ALE_HIGH);
        nxt_uartClk = uartClk_ff;
        if (nxt_aleCnt == 6'h00) begin
            nxt_uartClk = ~uartClk_ff;
        end
    end

    // Not held by the power-on reset: the strobe runs whenever powered
    // Count starts at the wrap so the first pulse is full width
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            aleCnt_ff  <= ALE_CYC - 6'h01;
            ale_ff     <= 1'b0;
            uartClk_ff <= 1'b0;
        end else if (ce) begin
            aleCnt_ff  <= nxt_aleCnt;
            ale_ff     <= nxt_ale;
            uartClk_ff <= nxt_uartClk;
        end
    end

    assign aleStrobe    = ale_ff;
    assign tx_bit_clock = uartClk_ff;

    // ------------------------------------------------------------------
    // Power-on reset and chip-select decode
    // ------------------------------------------------------------------
    rpio_por_timer #(
        .POR_CYC (POR_CYC)
    ) u_por (
        .clock              (clock),
        .rst_b              (rst_b),
        .ce                 (ce),
        .power_on_reset_n   (power_on_reset_n),
        .power_on_reset_pos (power_on_reset_pos)
    );

    logic [7:0] port2_ff;

    rpio_cs_decoder u_dec (
        .devAddr  (port2_ff[5:2]),
        .enableN  (port2_ff[`RPIO_A6_BIT]),
        .chipSelN (chipSelN)
    );

    // ------------------------------------------------------------------
    // Bus sequencer
    // ------------------------------------------------------------------
    rpio_state_t state_ff;
    rpio_state_t nxt_state;
    logic [11:0] wait_ff;
    logic [11:0] nxt_wait;
    logic [11:0] gap_ff;
    logic [11:0] nxt_gap;
    logic [2:0]  idx_ff;
    logic [2:0]  nxt_idx;
    logic [7:0]  nxt_port2;
    logic [7:0]  busOut_ff;
    logic [7:0]  nxt_busOut;
    logic        busOe_ff;
    logic        nxt_busOe;
    logic        latch_ff;
    logic        nxt_latch;
    logic [3:0]  row_ff;
    logic [3:0]  nxt_row;
    logic        strobe_ff;
    logic        nxt_strobe;
    logic [7:0]  rdData_ff;
    logic [7:0]  nxt_rdData;
    logic        rdValid_ff;
    logic        nxt_rdValid;
    logic        scanDone_ff;
    logic        nxt_scanDone;
    logic [31:0] sw_ff;
    logic [31:0] nxt_sw;
    logic        stepDone;
    logic        adcBlocked;

    assign stepDone   = (wait_ff == 12'h000);
    // Converter has no end-of-conversion line, so early reads are held off
    assign adcBlocked = (req.op == RPIO_OP_READ) && (req.devCode == `RPIO_CODE_ADC)
                        && (gap_ff != 12'h000);
    assign reqReady   = ce && power_on_reset_n && (state_ff == RPIO_ST_IDLE) && !adcBlocked;

    always_comb begin
        nxt_state    = state_ff;
        nxt_wait     = stepDone ? 12'h000 : wait_ff - 12'h001;
        nxt_gap      = (gap_ff == 12'h000) ? 12'h000 : gap_ff - 12'h001;
        nxt_idx      = idx_ff;
        nxt_port2    = port2_ff;
        nxt_busOut   = busOut_ff;
        nxt_busOe    = busOe_ff;
        nxt_latch    = latch_ff;
        nxt_row      = row_ff;
        nxt_strobe   = strobe_ff;
        nxt_rdData   = rdData_ff;
        nxt_rdValid  = 1'b0;
        nxt_scanDone = 1'b0;
        nxt_sw       = sw_ff;
        unique case (state_ff)
            RPIO_ST_IDLE: begin
                if (reqValid && reqReady) begin
                    nxt_wait = STEP - 12'h001;
                    nxt_row  = `RPIO_ROW_RESET;
                    unique case (req.op)
                        RPIO_OP_WRITE: begin
                            nxt_busOut = req.data;
                            nxt_busOe  = 1'b1;
                            nxt_latch  = 1'b0;
                            nxt_state  = RPIO_ST_WR_DRIVE;
                        end
                        RPIO_OP_READ: begin
                            nxt_busOe = 1'b0;
                            nxt_latch = 1'b0;
                            nxt_port2[5:0] = {req.devCode, req.char_position_code};
                            if (req.devCode == `RPIO_CODE_ADC) begin
                                nxt_gap = 12'(ADC_CYC);
                            end
                            nxt_state = RPIO_ST_RD_ADDR;
                        end
                        RPIO_OP_CHAN: begin
                            nxt_port2[3:0] = req.data[3:0];
                            nxt_strobe     = 1'b1;
                            nxt_state      = RPIO_ST_CH_SETUP;
                        end
                        RPIO_OP_SCAN: begin
                            nxt_idx   = 3'h0;
                            nxt_busOe = 1'b1;
                            nxt_latch = 1'b1;
                            if (diagMode) begin
                                nxt_busOut = colOneHot(3'h0);
                                nxt_state  = RPIO_ST_SW_COL;
                            end else begin
                                nxt_busOut = ledByte(ledData, 3'h0);
                                nxt_state  = RPIO_ST_LED_DATA;
                            end
                        end
                    endcase
                end
            end
            RPIO_ST_WR_DRIVE: begin
                if (stepDone) begin
                    nxt_port2[5:0] = {req.devCode, req.char_position_code};
                    nxt_wait       = STEP - 12'h001;
                    nxt_state      = RPIO_ST_WR_ADDR;
                end
            end
            RPIO_ST_WR_ADDR: begin
                if (stepDone) begin
                    nxt_port2[`RPIO_A6_BIT] = 1'b0;
                    nxt_wait  = STEP - 12'h001;
                    nxt_state = RPIO_ST_WR_SEL;
                end
            end
            RPIO_ST_WR_SEL: begin
                if (stepDone) begin
                    nxt_port2[`RPIO_A6_BIT] = 1'b1;
                    nxt_wait  = STEP - 12'h001;
                    nxt_state = RPIO_ST_FINISH;
                end
            end
            RPIO_ST_RD_ADDR: begin
                if (stepDone) begin
                    nxt_port2[`RPIO_A6_BIT] = 1'b0;
                    nxt_wait  = STEP - 12'h001;
                    nxt_state = RPIO_ST_RD_SEL;
                end
            end
            RPIO_ST_RD_SEL: begin
                // Synchroniser lag of two cycles still lands inside the select
                if (stepDone) begin
                    nxt_rdData  = busSync;
                    nxt_rdValid = 1'b1;
                    nxt_port2[`RPIO_A6_BIT] = 1'b1;
                    nxt_wait  = STEP - 12'h001;
                    nxt_state = RPIO_ST_FINISH;
                end
            end
            RPIO_ST_CH_SETUP: begin
                if (stepDone) begin
                    nxt_strobe = 1'b0;
                    nxt_wait   = STEP - 12'h001;
                    nxt_state  = RPIO_ST_CH_STROBE;
                end
            end
            RPIO_ST_CH_STROBE: begin
                if (stepDone) begin
                    nxt_strobe = 1'b1;
                    nxt_wait   = STEP - 12'h001;
                    nxt_state  = RPIO_ST_FINISH;
                end
            end
            RPIO_ST_LED_DATA: begin
                if (stepDone) begin
                    nxt_row[idx_ff[1:0]] = 1'b0;
                    nxt_wait  = 12'(LED_CYC - 1);
                    nxt_state = RPIO_ST_LED_ON;
                end
            end
            RPIO_ST_LED_ON: begin
                if (stepDone) begin
                    nxt_row  = `RPIO_ROW_RESET;
                    nxt_wait = STEP - 12'h001;
                    if (idx_ff == 3'(`RPIO_LED_GROUPS - 1)) begin
                        nxt_idx    = 3'h0;
                        nxt_busOut = colOneHot(3'h0);
                        nxt_state  = RPIO_ST_SW_COL;
                    end else begin
                        nxt_idx    = idx_ff + 3'h1;
                        nxt_busOut = ledByte(ledData, idx_ff + 3'h1);
                        nxt_state  = RPIO_ST_LED_DATA;
                    end
                end
            end
            RPIO_ST_SW_COL: begin
                if (stepDone) begin
                    nxt_sw[idx_ff*4 +: 4] = swSync;
                    nxt_wait = STEP - 12'h001;
                    if (idx_ff == 3'(`RPIO_SW_COLS - 1)) begin
                        nxt_busOe    = 1'b0;
                        nxt_latch    = 1'b0;
                        nxt_scanDone = 1'b1;
                        nxt_state    = RPIO_ST_IDLE;
                    end else begin
                        nxt_idx    = idx_ff + 3'h1;
                        nxt_busOut = colOneHot(idx_ff + 3'h1);
                    end
                end
            end
            RPIO_ST_FINISH: begin
                // Data held until after A6 rises, then the bus is let go
                if (stepDone) begin
                    nxt_busOe = 1'b0;
                    nxt_state = RPIO_ST_IDLE;
                end
            end
            default: begin
                nxt_state = RPIO_ST_IDLE;
            end
        endcase
    end

    // Reset drives all ports to ones; during power-on hold reqReady is low,
    // so the idle sequencer keeps these values with no extra branch
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_ff    <= RPIO_ST_IDLE;
            wait_ff     <= 12'h000;
            gap_ff      <= 12'h000;
            idx_ff      <= 3'h0;
            port2_ff    <= `RPIO_PORT2_RESET;
            busOut_ff   <= 8'hFF;
            busOe_ff    <= 1'b0;
            latch_ff    <= 1'b0;
            row_ff      <= `RPIO_ROW_RESET;
            strobe_ff   <= 1'b1;
            rdData_ff   <= 8'h00;
            rdValid_ff  <= 1'b0;
            scanDone_ff <= 1'b0;
            sw_ff       <= 32'h00000000;
        end else if (ce) begin
            state_ff    <= nxt_state;
            wait_ff     <= nxt_wait;
            gap_ff      <= nxt_gap;
            idx_ff      <= nxt_idx;
            port2_ff    <= nxt_port2;
            busOut_ff   <= nxt_busOut;
            busOe_ff    <= nxt_busOe;
            latch_ff    <= nxt_latch;
            row_ff      <= nxt_row;
            strobe_ff   <= nxt_strobe;
            rdData_ff   <= nxt_rdData;
            rdValid_ff  <= nxt_rdValid;
            scanDone_ff <= nxt_scanDone;
            sw_ff       <= nxt_sw;
        end
    end

    // ------------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------------
    assign busOut                 = busOut_ff;
    assign busOe                  = busOe_ff;
    assign busLatchMode           = latch_ff;
    assign addrOut                = port2_ff[6:0];
    assign tapeOut                = port2_ff[7];
    assign led_row_select         = row_ff;
    assign ledSinkOn              = ~row_ff;
    assign channel_latch_strobe_n = strobe_ff;
    assign rdData                 = rdData_ff;
    assign rdValid                = rdValid_ff;
    assign scanDone               = scanDone_ff;
    assign switchState            = sw_ff;

endmodule

/* hw/rpio_defs.svh */
// Constants of the remote panel I/O block: codes, field positions, timing.
// Assumes the 10 MHz system clock; included by bare name.
`ifndef RPIO_DEFS_SVH
`define RPIO_DEFS_SVH

// ----------------------------------------------------------------------
// Clock and timing figures
// ----------------------------------------------------------------------
`define RPIO_CLK_NS        100
`define RPIO_XTAL_KHZ      4608
`define RPIO_XTAL_PER_CYC  15
`define RPIO_ALE_HIGH_PCT  20
`define RPIO_STEP_NS       400
`define RPIO_LED_ON_US     300
`define RPIO_ADC_CONV_US   250
`define RPIO_POR_MS        250

// Derived cycle counts
`define RPIO_ALE_CYC   ((`RPIO_XTAL_PER_CYC * 1000000) / (`RPIO_XTAL_KHZ * `RPIO_CLK_NS))
`define RPIO_ALE_HIGH  ((`RPIO_ALE_CYC * `RPIO_ALE_HIGH_PCT) / 100)
`define RPIO_STEP_CYC  ((`RPIO_STEP_NS + `RPIO_CLK_NS - 1) / `RPIO_CLK_NS)
`define RPIO_LED_CYC   ((`RPIO_LED_ON_US * 1000) / `RPIO_CLK_NS)
`define RPIO_ADC_CYC   ((`RPIO_ADC_CONV_US * 1000 + `RPIO_CLK_NS - 1) / `RPIO_CLK_NS)
`define RPIO_POR_CYC   ((`RPIO_POR_MS * 1000000) / `RPIO_CLK_NS)

// ----------------------------------------------------------------------
// Device codes on A5..A2 and port layout
// ----------------------------------------------------------------------
`define RPIO_CODE_DISP_LAST 4'hB
`define RPIO_CODE_UART_TX   4'hC
`define RPIO_CODE_UART_RX   4'hD
`define RPIO_CODE_ADC       4'hE
`define RPIO_PORT2_RESET    8'hFF
`define RPIO_ROW_RESET      4'hF
`define RPIO_A6_BIT         6
`define RPIO_LED_GROUPS     4
`define RPIO_SW_COLS        8

`endif

/* hw/rpio_pkg.sv */
// Types shared by the remote panel I/O block.
// Assumes rpio_defs.svh holds the numeric constants.
package rpio_pkg;

    // ------------------------------------------------------------------
    // Request carried from the user side
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RPIO_OP_WRITE = 2'b00,
        RPIO_OP_READ  = 2'b01,
        RPIO_OP_CHAN  = 2'b10,
        RPIO_OP_SCAN  = 2'b11
    } rpio_op_t;

    typedef struct packed {
        rpio_op_t   op;
        logic [3:0] devCode;
        logic [1:0] char_position_code;
        logic [7:0] data;
    } rpio_req_t;

    // ------------------------------------------------------------------
    // Bus sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        RPIO_ST_IDLE      = 4'b0000,
        RPIO_ST_WR_DRIVE  = 4'b0001,
        RPIO_ST_WR_ADDR   = 4'b0010,
        RPIO_ST_WR_SEL    = 4'b0011,
        RPIO_ST_RD_ADDR   = 4'b0100,
        RPIO_ST_RD_SEL    = 4'b0101,
        RPIO_ST_CH_SETUP  = 4'b0110,
        RPIO_ST_CH_STROBE = 4'b0111,
        RPIO_ST_LED_DATA  = 4'b1000,
        RPIO_ST_LED_ON    = 4'b1001,
        RPIO_ST_SW_COL    = 4'b1010,
        RPIO_ST_FINISH    = 4'b1011
    } rpio_state_t;

endpackage

/* hw/rpio_cs_decoder.sv */
// Decoder of A5..A2 into sixteen active-low chip selects, gated by A6.
// Assumes the address and enable come from registers of the same clock.
`timescale 1ns/1ps
module rpio_cs_decoder
    import rpio_pkg::*;
(
    input  wire logic [3:0]  devAddr,
    input  wire logic        enableN,
    output logic      [15:0] chipSelN
);

    // ------------------------------------------------------------------
    // One-of-sixteen decode
    // ------------------------------------------------------------------
    // Enable high forces every select off, so address changes made
    // while A6 is high can never glitch a select
    always_comb begin
        if (enableN) begin
            chipSelN = 16'hFFFF;
        end else begin
            chipSelN = ~(16'h0001 << devAddr);
        end
    end

endmodule

/* hw/rpio_por_timer.sv */
// Power-on reset stretcher giving complementary reset levels.
// Assumes rst_b falls whenever power is applied or lost.
`timescale 1ns/1ps
`include "rpio_defs.svh"
module rpio_por_timer
    import rpio_pkg::*;
#(
    parameter int POR_CYC = `RPIO_POR_CYC
) (
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic ce,
    output logic      power_on_reset_n,
    output logic      power_on_reset_pos
);

    logic [21:0] cnt_ff;
    logic [21:0] nxt_cnt;
    logic        active_ff;
    logic        nxt_active;

    // ------------------------------------------------------------------
    // Hold-off counter
    // ------------------------------------------------------------------
    always_comb begin
        nxt_cnt    = cnt_ff;
        nxt_active = active_ff;
        if (active_ff) begin
            if (cnt_ff == 22'(POR_CYC - 1)) begin
                nxt_active = 1'b0;
            end else begin
                nxt_cnt = cnt_ff + 22'h000001;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff    <= 22'h000000;
            active_ff <= 1'b1;
        end else if (ce) begin
            cnt_ff    <= nxt_cnt;
            active_ff <= nxt_active;
        end
    end

    // Both polarities from the one flag so they never disagree
    assign power_on_reset_pos = active_ff;
    assign power_on_reset_n   = ~active_ff;

endmodule

/* bench/rpio_panel_io_asserts.sv */
// Checker of the panel I/O port timing.
// Assumes it is bound into rpio_panel_io.
`timescale 1ns/1ps
module rpio_panel_io_asserts (
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic [6:0]  addrOut,
    input wire logic [15:0] chipSelN,
    input wire logic [3:0]  led_row_select,
    input wire logic [3:0]  ledSinkOn,
    input wire logic        aleStrobe,
    input wire logic        tx_bit_clock,
    input wire logic        channel_latch_strobe_n,
    input wire logic        power_on_reset_n,
    input wire logic        power_on_reset_pos
);
    // ----
    // Pin relations
    // ----
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Strobe high six cycles in all, then low
    sequence s_aleHigh; aleStrobe[*5] ##1 !aleStrobe; endsequence
    property p_selOff; addrOut[6] |-> &chipSelN; endproperty
    a_selOff: assert property (p_selOff) else $error("select while A6 high");
    property p_dec; !addrOut[6] |-> chipSelN == ~(16'h0001 << addrOut[5:2]); endproperty
    a_dec: assert property (p_dec) else $error("wrong select decoded");
    property p_por; power_on_reset_n ^ power_on_reset_pos; endproperty
    a_por: assert property (p_por) else $error("resets not complementary");
    property p_sink; ledSinkOn == ~led_row_select; endproperty
    a_sink: assert property (p_sink) else $error("sink not inverted row");
    property p_ledIdle; !addrOut[6] |-> ledSinkOn == 4'h0; endproperty
    a_ledIdle: assert property (p_ledIdle) else $error("LED lit during transfer");
    property p_ale; $rose(aleStrobe) |=> s_aleHigh; endproperty
    a_ale: assert property (p_ale) else $error("strobe duty wrong");
    property p_tx; $changed(tx_bit_clock) |=> $stable(tx_bit_clock)[*8]; endproperty
    a_tx: assert property (p_tx) else $error("bit clock too fast");
    // Address frozen while A6 low
    property p_addr; $fell(addrOut[6]) |-> $stable(addrOut[5:0])[*4]; endproperty
    a_addr: assert property (p_addr) else $error("address moved under A6");
    property p_chan; $rose(channel_latch_strobe_n) |-> addrOut[6] && $stable(addrOut[3:0]); endproperty
    a_chan: assert property (p_chan) else $error("channel unstable at strobe");
endmodule
bind rpio_panel_io rpio_panel_io_asserts chk_u (.clock, .rst_b, .addrOut, .chipSelN, .led_row_select, .ledSinkOn,
    .aleStrobe, .tx_bit_clock, .channel_latch_strobe_n, .power_on_reset_n, .power_on_reset_pos);

/* bench/rpio_bus_partner.sv */
// Model of the chips on the shared bus and the switch matrix.
// Assumes the panel block drives selects and the buffered bus.
`timescale 1ns/1ps
module rpio_bus_partner (
    input  wire logic [15:0] chipSelN,
    input  wire logic [7:0]  busOut,
    input  wire logic        busLatchMode,
    output logic      [7:0]  busIn,
    output logic      [3:0]  switch_return_bits
);
    // Readers ignore A1-A0; a released bus shows no stale byte
    assign busIn = !chipSelN[13] ? 8'h5A : !chipSelN[14] ? 8'hC3 : ~busOut;
    // One key per column; pulldowns give zero off-scan
    assign switch_return_bits = busLatchMode ? busOut[3:0] | busOut[7:4] : 4'h0;
endmodule

/* bench/rpio_panel_io_tb_top.sv */
// Self-checking bench of the panel I/O block.
// Assumes the bus partner model and the bound checker.
`timescale 1ns/1ps
module rpio_panel_io_tb_top;
    import rpio_pkg::*;
    logic        clock = 1'b0, rst_b = 1'b0, ce = 1'b1, reqValid = 1'b0, diagMode = 1'b0;
    logic        charRx = 1'b0, frameIn = 1'b0, reqReady, rdValid, scanDone, busOe, busLatchMode, tapeOut;
    logic        strobeN, cpuIntN, frameErr, ale, txClk, porN, porPos;
    logic [3:0]  retBits, rowSel, sinkOn;
    logic [6:0]  addrOut;
    logic [7:0]  rdData, busIn, busOut;
    logic [15:0] chipSelN;
    logic [31:0] ledData = 32'h44332211, switchState;
    rpio_req_t   req = '0;
    int          n_mismatch = 0, compares = 0, cyc = 0, cyc0;
    rpio_panel_io #(.POR_CYC(20), .LED_CYC(8), .ADC_CYC(30)) dut_u (.clock, .rst_b, .ce, .reqValid, .req, .reqReady,
        .rdData, .rdValid, .ledData, .diagMode, .scanDone, .switchState, .busIn, .busOut, .busOe, .busLatchMode,
        .addrOut, .tapeOut, .chipSelN, .channel_latch_strobe_n(strobeN), .switch_return_bits(retBits),
        .led_row_select(rowSel), .ledSinkOn(sinkOn), .char_received(charRx), .framing_error_input(frameIn),
        .cpuIntN, .frameErrFlag(frameErr), .aleStrobe(ale), .tx_bit_clock(txClk),
        .power_on_reset_n(porN), .power_on_reset_pos(porPos));
    rpio_bus_partner peer_u (.chipSelN, .busOut, .busLatchMode, .busIn, .switch_return_bits(retBits));
    // ----
    // Clock, watchdog and shared tasks
    // ----
    always #50 clock = ~clock;
    // Run needs a few hundred cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask
    // Offer at a falling edge, hold until taken
    task automatic send(input rpio_op_t op, input logic [3:0] code, input logic [7:0] data);
        req = '{op, code, 2'h2, data};
        reqValid = 1'b1;
        for (int i = 0; i < 200 && !reqReady; i++) @(negedge clock);
        @(negedge clock);
        reqValid = 1'b0;
    endtask
    task automatic t_read(input logic [3:0] code, input logic [7:0] exp);
        send(RPIO_OP_READ, code, 8'h00);
        chk(busOe, 1'b0, "bus not released");
        for (int i = 0; i < 20 && !rdValid; i++) @(negedge clock);
        chk({rdValid, rdData}, {1'b1, exp}, "read data");
    endtask
    task automatic t_write();
        for (int c = 0; c < 15; c++) begin
            send(RPIO_OP_WRITE, c[3:0], 8'h41 + c[7:0]);
            repeat (9) @(negedge clock);
            chk({busOe, addrOut, busOut, chipSelN}, {1'b1, 1'b0, c[3:0], 2'h2, 8'h41 + c[7:0],
                ~(16'h0001 << c)}, "write cycle");
        end
    endtask
    task automatic t_scan(input logic d, input int lim);
        int n;
        diagMode = d;
        send(RPIO_OP_SCAN, 4'h0, 8'h00);
        repeat (5) @(negedge clock);
        chk({busOe, busLatchMode, sinkOn, busOut}, d ? 14'h3002 : 14'h3111, "scan start");
        for (n = 0; n < lim && !scanDone; n++) @(negedge clock);
        chk({scanDone, switchState}, {1'b1, 32'h84218421}, "switch scan");
    endtask
    task automatic give_verdict();
        $display("Mismatches %0d, compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clock);
        rst_b = 1'b1;
        chk({addrOut, tapeOut, chipSelN, porN, porPos, rowSel}, 30'h3FFFFFDF, "reset levels");
        repeat (25) @(negedge clock);
        chk({porN, porPos}, 2'h2, "reset release");
        t_write();
        t_read(4'hD, 8'h5A);
        t_read(4'hE, 8'hC3);
        cyc0 = cyc;
        t_read(4'hE, 8'hC3);
        chk(cyc - cyc0 >= 30, 1'b1, "conversion spacing");
        send(RPIO_OP_CHAN, 4'h0, 8'h03);
        repeat (5) @(negedge clock);
        chk({strobeN, addrOut[6], addrOut[3:0]}, 6'h13, "channel setup");
        t_scan(1'b0, 200);
        t_scan(1'b1, 40);
        charRx = 1'b1;
        frameIn = 1'b1;
        repeat (4) @(negedge clock);
        chk({cpuIntN, frameErr}, 2'h1, "interrupt and framing");
        give_verdict();
    end
endmodule
